// File: sau_store_unit.sv
`include "sau_defines.svh"

// Summary of operation
// R1 - word store writes all 32 source bits
// R2 - word address not multiple of four faults
// R3 - word post-modify steps pointer by four
// R4 - small word offset unsigned, zero to sixty
// R5 - frame pointer minus offset four to 128
// R6 - large word offset added or subtracted
// R7 - store first, then add second pointer register
// R8 - software names two distinct pointers there
// R9 - index registers with modify-register post-increment
// R10 - 32-bit forms refused in parallel issue
// R11 - upper-half store writes source bits 31:16
// R12 - odd half-word address faults, no store
// R13 - upper-half index post-modify steps by two
// R14 - upper-half forms include pointer plus pointer
// R15 - small half offset even, zero to thirty
// R16 - large half offset added or subtracted
// R17 - eight data, eight pointer, four index registers
// R18 - lower-half store writes bits 15:0, step two
// R19 - no flags touched, no privilege check
// R20 - offset forms leave pointer unchanged
// R21 - fault suppresses write and post-modify
module sau_store_unit (
	input wire logic SYS_CLK_I,
	input wire logic RST_N_I,
	input wire logic REQ_VALID_I,
	input wire sau_pkg::sau_req_s REQ_I,
	output logic REQ_READY_O,
	output logic MEM_VALID_O,
	output sau_pkg::sau_mem_s MEM_O,
	input wire logic MEM_READY_I,
	output logic DONE_O,
	output logic MISALIGN_O,
	output logic ISSUE_ERR_O,
	input wire sau_pkg::sau_load_s LOAD_I,
	input wire sau_pkg::sau_rsel_s RSEL_I,
	output sau_pkg::sau_word_t RDATA_O
);
	// register files
	sau_pkg::sau_word_t data_file [8]; // R17
	sau_pkg::sau_word_t ptr_file [8]; // R17
	sau_pkg::sau_word_t idx_file [4]; // R17
	sau_pkg::sau_word_t mod_file [4]; // R17

	sau_pkg::sau_word_t base_val;
	sau_pkg::sau_word_t aux_val;
	sau_pkg::sau_word_t src_val;
	sau_pkg::sau_word_t ea;
	sau_pkg::sau_word_t upd_val;
	logic upd_en;
	logic large_enc;
	logic misaligned;
	logic accept;
	logic issue_bad;
	logic go;
	logic complete;
	logic [15:0] half_val;
	sau_pkg::sau_mem_s mem_next;

	logic busy_reg;
	sau_pkg::sau_mem_s mem_reg;
	logic done_reg;
	logic misalign_reg;
	logic issue_err_reg;
	logic upd_en_reg;
	sau_pkg::sau_file_e upd_file_reg;
	logic [2:0] upd_sel_reg;
	sau_pkg::sau_word_t upd_val_reg;
	sau_pkg::sau_word_t rdata_reg;

	assign REQ_READY_O = !busy_reg;
	assign accept = REQ_VALID_I && !busy_reg;
	assign complete = busy_reg && MEM_READY_I;
	assign MEM_VALID_O = busy_reg;
	assign MEM_O = mem_reg;
	assign DONE_O = done_reg;
	assign MISALIGN_O = misalign_reg;
	assign ISSUE_ERR_O = issue_err_reg;
	assign RDATA_O = rdata_reg;

	// operand selection
	always_comb begin
		if (REQ_I.base_is_idx) begin
			base_val = idx_file[REQ_I.base_sel[1:0]]; // R9
		end else if (REQ_I.mode == sau_pkg::SAU_FP_REL) begin
			base_val = ptr_file[`SAU_FP_SLOT]; // R5
		end else begin
			base_val = ptr_file[REQ_I.base_sel]; // R1
		end
	end

	always_comb begin
		if (REQ_I.mode == sau_pkg::SAU_POST_MOD) begin
			aux_val = mod_file[REQ_I.aux_sel[1:0]]; // R9
		end else begin
			aux_val = ptr_file[REQ_I.aux_sel]; // R7 R14
		end
	end

	assign src_val = data_file[REQ_I.src_sel];

	sau_addr_gen u_addr_gen (
		.kind_i(REQ_I.kind),
		.mode_i(REQ_I.mode),
		.base_i(base_val),
		.aux_i(aux_val),
		.offset_i(REQ_I.offset),
		.ea_o(ea),
		.upd_o(upd_val),
		.upd_en_o(upd_en),
		.large_o(large_enc)
	);

	sau_align_chk u_align_chk (
		.kind_i(REQ_I.kind),
		.ea_low_i(ea[1:0]),
		.misaligned_o(misaligned)
	);

	// privilege and flags are not consulted: R19
	assign issue_bad = large_enc && REQ_I.parallel; // R10
	assign go = accept && !issue_bad && !misaligned; // R21

	// write data lanes
	always_comb begin
		half_val = src_val[15:0];
		mem_next.addr = ea;
		mem_next.data = src_val;
		mem_next.be = `SAU_BE_WORD;
		unique case (REQ_I.kind)
			sau_pkg::SAU_WORD: begin
				mem_next.data = src_val; // R1
				mem_next.be = `SAU_BE_WORD;
			end
			sau_pkg::SAU_HIGH: begin
				half_val = src_val[31:16]; // R11
				mem_next.data = {half_val, half_val};
				mem_next.be = ea[1] ? `SAU_BE_HALF_HI : `SAU_BE_HALF_LO;
			end
			sau_pkg::SAU_LOW: begin
				half_val = src_val[15:0]; // R18
				mem_next.data = {half_val, half_val};
				mem_next.be = ea[1] ? `SAU_BE_HALF_HI : `SAU_BE_HALF_LO;
			end
			default: begin
				mem_next.be = `SAU_BE_NONE;
			end
		endcase
	end

	// outstanding memory write
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			busy_reg <= 1'b0;
			mem_reg <= '0;
		end else if (go) begin
			busy_reg <= 1'b1;
			mem_reg <= mem_next;
		end else if (complete) begin
			busy_reg <= 1'b0;
		end
	end

	// event pulses
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			done_reg <= 1'b0;
			misalign_reg <= 1'b0;
			issue_err_reg <= 1'b0;
		end else begin
			done_reg <= complete;
			misalign_reg <= accept && !issue_bad && misaligned; // R2 R12
			issue_err_reg <= accept && issue_bad; // R10
		end
	end

	// pending post-modify, applied once the write is taken
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			upd_en_reg <= 1'b0;
			upd_file_reg <= sau_pkg::SAU_FILE_PTR;
			upd_sel_reg <= `SAU_SEL_RST;
			upd_val_reg <= `SAU_REG_RST;
		end else if (go) begin
			upd_en_reg <= upd_en; // R20
			upd_file_reg <= REQ_I.base_is_idx ? sau_pkg::SAU_FILE_IDX
				: sau_pkg::SAU_FILE_PTR;
			upd_sel_reg <= REQ_I.base_sel;
			upd_val_reg <= upd_val; // R3 R7 R13
		end
	end

	// register files; post-modify wins over a load to the same entry
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_regs
			logic upd_ptr;
			assign upd_ptr = complete && upd_en_reg // R7 R8
				&& upd_file_reg == sau_pkg::SAU_FILE_PTR
				&& upd_sel_reg == 3'(g);
			always_ff @(posedge SYS_CLK_I) begin
				if (!RST_N_I) begin
					data_file[g] <= `SAU_REG_RST;
				end else if (LOAD_I.valid && LOAD_I.file ==
					sau_pkg::SAU_FILE_DATA && LOAD_I.sel == 3'(g)) begin
					data_file[g] <= LOAD_I.value;
				end
			end
			always_ff @(posedge SYS_CLK_I) begin
				if (!RST_N_I) begin
					ptr_file[g] <= `SAU_REG_RST;
				end else if (upd_ptr) begin
					ptr_file[g] <= upd_val_reg; // R3 R7 R14
				end else if (LOAD_I.valid && LOAD_I.file ==
					sau_pkg::SAU_FILE_PTR && LOAD_I.sel == 3'(g)) begin
					ptr_file[g] <= LOAD_I.value;
				end
			end
			if (g < 4) begin : g_dag
				logic upd_idx;
				assign upd_idx = complete && upd_en_reg
					&& upd_file_reg == sau_pkg::SAU_FILE_IDX
					&& upd_sel_reg[1:0] == 2'(g);
				always_ff @(posedge SYS_CLK_I) begin
					if (!RST_N_I) begin
						idx_file[g] <= `SAU_REG_RST;
					end else if (upd_idx) begin
						idx_file[g] <= upd_val_reg; // R9 R13
					end else if (LOAD_I.valid && LOAD_I.file ==
						sau_pkg::SAU_FILE_IDX && LOAD_I.sel == 3'(g)) begin
						idx_file[g] <= LOAD_I.value;
					end
				end
				always_ff @(posedge SYS_CLK_I) begin
					if (!RST_N_I) begin
						mod_file[g] <= `SAU_REG_RST;
					end else if (LOAD_I.valid && LOAD_I.file ==
						sau_pkg::SAU_FILE_MOD && LOAD_I.sel == 3'(g)) begin
						mod_file[g] <= LOAD_I.value;
					end
				end
			end
		end
	endgenerate

	// readback
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			rdata_reg <= `SAU_REG_RST;
		end else begin
			unique case (RSEL_I.file)
				sau_pkg::SAU_FILE_DATA: rdata_reg <= data_file[RSEL_I.sel];
				sau_pkg::SAU_FILE_PTR: rdata_reg <= ptr_file[RSEL_I.sel];
				sau_pkg::SAU_FILE_IDX: rdata_reg <= idx_file[RSEL_I.sel[1:0]];
				sau_pkg::SAU_FILE_MOD: rdata_reg <= mod_file[RSEL_I.sel[1:0]];
			endcase
		end
	end

	// checks
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RST_N_I);

	logic acc_word;
	logic acc_half;
	assign acc_word = accept && !issue_bad
		&& REQ_I.kind == sau_pkg::SAU_WORD;
	assign acc_half = accept && !issue_bad
		&& REQ_I.kind != sau_pkg::SAU_WORD;

	a_word_align_fault: assert property ( // R2
		acc_word && ea[1:0] != 2'h0 |=> MISALIGN_O && !MEM_VALID_O)
		else $error("misaligned word store not faulted");

	a_half_align_fault: assert property ( // R12
		acc_half && ea[0] |=> MISALIGN_O && !MEM_VALID_O && !DONE_O)
		else $error("odd half-word store not faulted");

	a_word_full_data: assert property ( // R1
		go && REQ_I.kind == sau_pkg::SAU_WORD
		|=> MEM_VALID_O && MEM_O.be == 4'hF
		&& MEM_O.data == $past(src_val))
		else $error("word store data or lanes wrong");

	a_high_half_lane: assert property ( // R11
		go && REQ_I.kind == sau_pkg::SAU_HIGH
		|=> MEM_O.data[15:0] == $past(src_val[31:16])
		&& MEM_O.data[31:16] == $past(src_val[31:16]))
		else $error("upper-half store data wrong");

	a_low_half_lane: assert property ( // R18
		go && REQ_I.kind == sau_pkg::SAU_LOW
		|=> MEM_O.data[15:0] == $past(src_val[15:0])
		&& MEM_O.be == ($past(ea[1]) ? 4'hC : 4'h3))
		else $error("lower-half store data or lanes wrong");

	a_post_inc_word: assert property ( // R3
		go && REQ_I.kind == sau_pkg::SAU_WORD && !REQ_I.base_is_idx
		&& REQ_I.mode == sau_pkg::SAU_POST_INC
		|=> MEM_O.addr == $past(base_val)
		&& upd_val_reg == $past(base_val) + 32'h4)
		else $error("word post-increment not by four");

	a_frame_rel_addr: assert property ( // R5
		go && REQ_I.mode == sau_pkg::SAU_FP_REL && !REQ_I.base_is_idx
		|=> MEM_O.addr == $past(ptr_file[7])
		- {24'h000000, $past(REQ_I.offset[7:0])})
		else $error("frame-relative address wrong");

	a_offset_no_wb: assert property ( // R20
		go && (REQ_I.mode == sau_pkg::SAU_OFF_SMALL
		|| REQ_I.mode == sau_pkg::SAU_OFF_ADD
		|| REQ_I.mode == sau_pkg::SAU_OFF_SUB)
		|=> !upd_en_reg)
		else $error("offset store scheduled a write-back");

	a_parallel_refuse: assert property ( // R10
		accept && REQ_I.parallel && (REQ_I.mode == sau_pkg::SAU_OFF_ADD
		|| REQ_I.mode == sau_pkg::SAU_OFF_SUB)
		|=> ISSUE_ERR_O && !MEM_VALID_O && !MISALIGN_O)
		else $error("32-bit form issued in parallel");

	a_fault_no_update: assert property ( // R21
		MISALIGN_O |-> !busy_reg ##1 !DONE_O)
		else $error("faulted store went on");

	a_done_follows: assert property ( // R7
		complete && upd_en_reg && upd_file_reg == sau_pkg::SAU_FILE_PTR
		|=> DONE_O && ptr_file[$past(upd_sel_reg)] == $past(upd_val_reg))
		else $error("post-modify not applied after write");

	c_word_store: cover property (
		go && REQ_I.kind == sau_pkg::SAU_WORD ##[1:4] DONE_O);
	c_half_fault: cover property (acc_half ##1 MISALIGN_O);
	c_post_mod: cover property (
		go && REQ_I.mode == sau_pkg::SAU_POST_MOD ##[1:4] DONE_O);
	c_par_refuse: cover property (ISSUE_ERR_O);
endmodule

// File: sau_defines.svh
`ifndef SAU_DEFINES_SVH
`define SAU_DEFINES_SVH

// post-modify steps in bytes
`define SAU_WORD_STEP 32'h0000_0004
`define SAU_HALF_STEP 32'h0000_0002

// offset field masks, in bytes
`define SAU_SMALL_WORD_MASK 17'h0003F
`define SAU_FRAME_MASK 17'h000FF
`define SAU_LARGE_WORD_MASK 17'h1FFFF
`define SAU_SMALL_HALF_MASK 17'h0001F
`define SAU_LARGE_HALF_MASK 17'h0FFFF
`define SAU_OFF_PAD 15'h0000

// pointer file slots
`define SAU_SP_SLOT 3'h6
`define SAU_FP_SLOT 3'h7

// alignment fields
`define SAU_WORD_ALIGN_MASK 2'h3
`define SAU_ZERO_LOW2 2'h0

// byte enables
`define SAU_BE_WORD 4'hF
`define SAU_BE_HALF_LO 4'h3
`define SAU_BE_HALF_HI 4'hC
`define SAU_BE_NONE 4'h0

// reset values
`define SAU_REG_RST 32'h0000_0000
`define SAU_SEL_RST 3'h0

`endif

// File: sau_pkg.sv
package sau_pkg;

	typedef logic [31:0] sau_word_t;

	typedef enum logic [1:0] {
		SAU_WORD = 2'b00,
		SAU_HIGH = 2'b01,
		SAU_LOW = 2'b10
	} sau_kind_e;

	typedef enum logic [3:0] {
		SAU_IND = 4'b0000,
		SAU_POST_INC = 4'b0001,
		SAU_POST_DEC = 4'b0010,
		SAU_OFF_SMALL = 4'b0011,
		SAU_OFF_ADD = 4'b0100,
		SAU_OFF_SUB = 4'b0101,
		SAU_POST_IDX = 4'b0110,
		SAU_FP_REL = 4'b0111,
		SAU_POST_MOD = 4'b1000
	} sau_mode_e;

	typedef enum logic [1:0] {
		SAU_FILE_DATA = 2'b00,
		SAU_FILE_PTR = 2'b01,
		SAU_FILE_IDX = 2'b10,
		SAU_FILE_MOD = 2'b11
	} sau_file_e;

	typedef struct packed {
		sau_kind_e kind;
		sau_mode_e mode;
		logic base_is_idx;
		logic [2:0] base_sel;
		logic [2:0] aux_sel;
		logic [2:0] src_sel;
		logic [16:0] offset;
		logic parallel;
	} sau_req_s;

	typedef struct packed {
		sau_word_t addr;
		sau_word_t data;
		logic [3:0] be;
	} sau_mem_s;

	typedef struct packed {
		logic valid;
		sau_file_e file;
		logic [2:0] sel;
		sau_word_t value;
	} sau_load_s;

	typedef struct packed {
		sau_file_e file;
		logic [2:0] sel;
	} sau_rsel_s;

endpackage

// File: sau_addr_gen.sv
`include "sau_defines.svh"

module sau_addr_gen (
	input wire sau_pkg::sau_kind_e kind_i,
	input wire sau_pkg::sau_mode_e mode_i,
	input wire sau_pkg::sau_word_t base_i,
	input wire sau_pkg::sau_word_t aux_i,
	input wire logic [16:0] offset_i,
	output sau_pkg::sau_word_t ea_o,
	output sau_pkg::sau_word_t upd_o,
	output logic upd_en_o,
	output logic large_o
);
	sau_pkg::sau_word_t step;
	sau_pkg::sau_word_t offz;
	logic [16:0] mask;
	logic is_word;

	assign is_word = (kind_i == sau_pkg::SAU_WORD);
	assign step = is_word ? `SAU_WORD_STEP : `SAU_HALF_STEP; // R3 R13 R18

	always_comb begin
		unique case (mode_i)
			sau_pkg::SAU_OFF_SMALL: mask = is_word ? `SAU_SMALL_WORD_MASK
				: `SAU_SMALL_HALF_MASK; // R4 R15
			sau_pkg::SAU_OFF_ADD, sau_pkg::SAU_OFF_SUB: mask = is_word
				? `SAU_LARGE_WORD_MASK : `SAU_LARGE_HALF_MASK; // R6 R16
			sau_pkg::SAU_FP_REL: mask = `SAU_FRAME_MASK; // R5
			default: mask = 17'h00000;
		endcase
	end

	assign offz = {`SAU_OFF_PAD, offset_i & mask};

	always_comb begin
		ea_o = base_i;
		upd_o = base_i;
		upd_en_o = 1'b0;
		large_o = 1'b0;
		unique case (mode_i)
			sau_pkg::SAU_IND: begin
			end
			sau_pkg::SAU_POST_INC: begin
				upd_o = base_i + step; // R3
				upd_en_o = 1'b1;
			end
			sau_pkg::SAU_POST_DEC: begin
				upd_o = base_i - step; // R3
				upd_en_o = 1'b1;
			end
			sau_pkg::SAU_OFF_SMALL: ea_o = base_i + offz; // R4 R15 R20
			sau_pkg::SAU_OFF_ADD: begin
				ea_o = base_i + offz; // R6 R16 R20
				large_o = 1'b1;
			end
			sau_pkg::SAU_OFF_SUB: begin
				ea_o = base_i - offz; // R6 R16 R20
				large_o = 1'b1;
			end
			sau_pkg::SAU_POST_IDX, sau_pkg::SAU_POST_MOD: begin
				upd_o = base_i + aux_i; // R7 R9 R14
				upd_en_o = 1'b1;
			end
			sau_pkg::SAU_FP_REL: ea_o = base_i - offz; // R5 R20
			default: begin
			end
		endcase
	end
endmodule

// File: sau_align_chk.sv
`include "sau_defines.svh"

module sau_align_chk (
	input wire sau_pkg::sau_kind_e kind_i,
	input wire logic [1:0] ea_low_i,
	output logic misaligned_o
);
	always_comb begin
		if (kind_i == sau_pkg::SAU_WORD) begin
			misaligned_o = ((ea_low_i & `SAU_WORD_ALIGN_MASK)
				!= `SAU_ZERO_LOW2); // R2
		end else begin
			misaligned_o = ea_low_i[0]; // R12
		end
	end
endmodule

// File: sau_mem_model.sv
module sau_mem_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic valid_i,
	input wire logic [3:0] wait_i,
	output logic ready_o,
	output logic [7:0] writes_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_reg;
	// accepts after wait_i stall cycles
	assign ready_o = valid_i && (cnt_reg == wait_i);
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || !valid_i || ready_o) begin
			cnt_reg <= 4'h0;
		end else begin
			cnt_reg <= cnt_reg + 4'h1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			writes_o <= 8'h00;
		end else if (valid_i && ready_o) begin
			writes_o <= writes_o + 8'h01;
		end
	end
endmodule

// File: tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam sau_pkg::sau_kind_e W = sau_pkg::SAU_WORD,
		H = sau_pkg::SAU_HIGH, L = sau_pkg::SAU_LOW;
	localparam sau_pkg::sau_mode_e IND = sau_pkg::SAU_IND,
		PINC = sau_pkg::SAU_POST_INC, PDEC = sau_pkg::SAU_POST_DEC,
		OSML = sau_pkg::SAU_OFF_SMALL, OADD = sau_pkg::SAU_OFF_ADD,
		OSUB = sau_pkg::SAU_OFF_SUB, PIDX = sau_pkg::SAU_POST_IDX,
		FREL = sau_pkg::SAU_FP_REL, PMOD = sau_pkg::SAU_POST_MOD;
	localparam sau_pkg::sau_file_e DF = sau_pkg::SAU_FILE_DATA,
		PF = sau_pkg::SAU_FILE_PTR, XF = sau_pkg::SAU_FILE_IDX,
		MF = sau_pkg::SAU_FILE_MOD;
	logic sys_clk, rst_n, req_valid, req_ready, mem_valid, mem_ready;
	logic done, misalign, issue_err;
	sau_pkg::sau_req_s req;
	sau_pkg::sau_mem_s mem;
	sau_pkg::sau_load_s load;
	sau_pkg::sau_rsel_s rsel;
	sau_pkg::sau_word_t rdata;
	logic [3:0] slow;
	logic [7:0] writes;
	logic [31:0] rv [8];
	int errors, checks, cycles;

	sau_store_unit i_dut (.SYS_CLK_I(sys_clk), .RST_N_I(rst_n),
		.REQ_VALID_I(req_valid), .REQ_I(req), .REQ_READY_O(req_ready),
		.MEM_VALID_O(mem_valid), .MEM_O(mem), .MEM_READY_I(mem_ready),
		.DONE_O(done), .MISALIGN_O(misalign), .ISSUE_ERR_O(issue_err),
		.LOAD_I(load), .RSEL_I(rsel), .RDATA_O(rdata));
	sau_mem_model i_mem (.clk_i(sys_clk), .rst_n_i(rst_n),
		.valid_i(mem_valid), .wait_i(slow), .ready_o(mem_ready),
		.writes_o(writes));

	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			conclude();
		end
	end

	task automatic conclude();
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [67:0] got, input logic [67:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic ld(input sau_pkg::sau_file_e f, input logic [2:0] sl,
		input logic [31:0] v);
		load = '{1'b1, f, sl, v};
		if (f == DF) begin
			rv[sl] = v;
		end
		@(posedge sys_clk);
		#1;
		load.valid = 1'b0;
		@(posedge sys_clk);
		#1;
	endtask

	task automatic rd(input sau_pkg::sau_file_e f, input logic [2:0] sl,
		input logic [31:0] v);
		rsel = '{f, sl};
		@(posedge sys_clk);
		#1;
		chk(rdata, v);
	endtask

	// b is {index file, slot}; res 0 good, 1 misaligned, 2 issue refused
	task automatic store(input sau_pkg::sau_kind_e k,
		input sau_pkg::sau_mode_e m, input logic [3:0] b,
		input logic [2:0] a, input logic [2:0] s, input logic [16:0] o,
		input logic par, input logic [1:0] res, input logic [31:0] ea);
		logic [15:0] hv;
		sau_pkg::sau_mem_s em;
		logic [7:0] w0;
		int n;
		hv = (k == H) ? rv[s][31:16] : rv[s][15:0];
		em.addr = ea;
		em.data = (k == W) ? rv[s] : {hv, hv};
		em.be = (k == W) ? 4'hF : (ea[1] ? 4'hC : 4'h3);
		w0 = writes;
		req = '{k, m, b[3], b[2:0], a, s, o, par};
		req_valid = 1'b1;
		@(posedge sys_clk);
		#1;
		req_valid = 1'b0;
		chk(mem_valid, res == 2'h0);
		chk(misalign, res == 2'h1);
		chk(issue_err, res == 2'h2);
		if (res == 2'h0) begin
			chk(mem, em);
			chk(req_ready, 1'b0);
			n = 0;
			while (done !== 1'b1 && n < 20) begin
				@(posedge sys_clk);
				#1;
				n++;
			end
			chk(done, 1'b1);
			chk(writes, w0 + 8'h01);
		end else begin
			@(posedge sys_clk);
			#1;
			chk(misalign | issue_err, 1'b0);
			chk(writes, w0);
		end
	endtask

	task automatic s_word();
		ld(PF, 3'h1, 32'h0000_0100);
		store(W, PINC, 4'h1, 3'h0, 3'h3, 17'h0, 1'b0, 2'h0, 32'h100);
		rd(PF, 3'h1, 32'h0000_0104);
		slow = 4'h3;
		store(W, PDEC, 4'h1, 3'h0, 3'h3, 17'h0, 1'b0, 2'h0, 32'h104);
		slow = 4'h0;
		rd(PF, 3'h1, 32'h0000_0100);
		ld(PF, 3'h6, 32'h0000_0500);
		store(W, PINC, 4'h6, 3'h0, 3'h5, 17'h0, 1'b0, 2'h0, 32'h500);
		rd(PF, 3'h6, 32'h0000_0504);
	endtask

	task automatic s_offsets();
		ld(PF, 3'h2, 32'h0000_1000);
		store(W, OSML, 4'h2, 3'h0, 3'h3, 17'h3C, 1'b0, 2'h0, 32'h103C);
		store(W, OADD, 4'h2, 3'h0, 3'h3, 17'h1FFFC, 1'b0, 2'h0, 32'h20FFC);
		store(W, OSUB, 4'h2, 3'h0, 3'h3, 17'h1FFFC, 1'b0, 2'h0,
			32'hFFFE_1004);
		rd(PF, 3'h2, 32'h0000_1000);
		ld(PF, 3'h7, 32'h0000_0800);
		store(W, FREL, 4'h0, 3'h0, 3'h5, 17'h80, 1'b0, 2'h0, 32'h780);
		store(W, FREL, 4'h0, 3'h0, 3'h5, 17'h4, 1'b0, 2'h0, 32'h7FC);
		rd(PF, 3'h7, 32'h0000_0800);
	endtask

	task automatic s_index();
		ld(PF, 3'h0, 32'h0000_0200);
		ld(PF, 3'h4, 32'h0000_0030);
		// distinct pointers for the index post-increment
		store(W, PIDX, 4'h0, 3'h4, 3'h3, 17'h0, 1'b0, 2'h0, 32'h200);
		rd(PF, 3'h0, 32'h0000_0230);
		ld(XF, 3'h2, 32'h0000_0400);
		ld(MF, 3'h0, 32'h0000_0018);
		store(W, IND, 4'hA, 3'h0, 3'h5, 17'h0, 1'b0, 2'h0, 32'h400);
		store(W, PMOD, 4'hA, 3'h0, 3'h5, 17'h0, 1'b0, 2'h0, 32'h400);
		rd(XF, 3'h2, 32'h0000_0418);
		store(W, PINC, 4'hA, 3'h0, 3'h5, 17'h0, 1'b0, 2'h0, 32'h418);
		rd(XF, 3'h2, 32'h0000_041C);
	endtask

	task automatic s_faults();
		ld(PF, 3'h3, 32'h0000_0102);
		store(W, IND, 4'h3, 3'h0, 3'h3, 17'h0, 1'b0, 2'h1, 32'h0);
		store(W, PINC, 4'h3, 3'h0, 3'h3, 17'h0, 1'b0, 2'h1, 32'h0);
		rd(PF, 3'h3, 32'h0000_0102);
		ld(XF, 3'h1, 32'h0000_0301);
		store(H, PINC, 4'h9, 3'h0, 3'h5, 17'h0, 1'b0, 2'h1, 32'h0);
		rd(XF, 3'h1, 32'h0000_0301);
		store(L, PINC, 4'h3, 3'h0, 3'h5, 17'h0, 1'b0, 2'h0, 32'h102);
		rd(PF, 3'h3, 32'h0000_0104);
		store(L, PDEC, 4'h3, 3'h0, 3'h5, 17'h0, 1'b0, 2'h0, 32'h104);
		rd(PF, 3'h3, 32'h0000_0102);
		store(W, OADD, 4'h2, 3'h0, 3'h3, 17'h4, 1'b1, 2'h2, 32'h0);
		store(L, OSUB, 4'h2, 3'h0, 3'h3, 17'h2, 1'b1, 2'h2, 32'h0);
		store(W, IND, 4'h1, 3'h0, 3'h3, 17'h0, 1'b1, 2'h0, 32'h100);
	endtask

	task automatic s_half();
		ld(XF, 3'h1, 32'h0000_0300);
		store(H, PINC, 4'h9, 3'h0, 3'h5, 17'h0, 1'b0, 2'h0, 32'h300);
		rd(XF, 3'h1, 32'h0000_0302);
		store(H, PDEC, 4'h9, 3'h0, 3'h5, 17'h0, 1'b0, 2'h0, 32'h302);
		rd(XF, 3'h1, 32'h0000_0300);
		store(H, PIDX, 4'h0, 3'h4, 3'h5, 17'h0, 1'b0, 2'h0, 32'h230);
		rd(PF, 3'h0, 32'h0000_0260);
		store(L, OSML, 4'h2, 3'h0, 3'h5, 17'h1E, 1'b0, 2'h0, 32'h101E);
		store(L, OADD, 4'h2, 3'h0, 3'h5, 17'hFFFE, 1'b0, 2'h0, 32'h10FFE);
		store(L, OSUB, 4'h2, 3'h0, 3'h5, 17'hFFFE, 1'b0, 2'h0,
			32'hFFFF_1002);
	endtask

	initial begin
		sys_clk = 1'b0;
		rst_n = 1'b0;
		req_valid = 1'b0;
		req = '0;
		load = '0;
		rsel = '0;
		slow = 4'h0;
		errors = 0;
		checks = 0;
		cycles = 0;
		repeat (16) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		chk(req_ready, 1'b1);
		rd(DF, 3'h3, 32'h0000_0000);
		ld(DF, 3'h3, 32'h1234_5678);
		ld(DF, 3'h5, 32'hCAFE_BEEF);
		s_word();
		s_offsets();
		s_index();
		s_faults();
		s_half();
		conclude();
	end
endmodule
